// ==== logic/lafsm_map.vh ====
// constants for the line activation state machine
`ifndef LAFSM_MAP_VH
`define LAFSM_MAP_VH

// ----------------------------------------
// transmitted line signal codes
// ----------------------------------------
`define LAFSM_TX_QUIET       3'h0
`define LAFSM_TX_WAKE        3'h1
`define LAFSM_TX_TRAIN       3'h2
`define LAFSM_TX_PREACT      3'h3
`define LAFSM_TX_ACTIVE      3'h4

// ----------------------------------------
// state codes (one-hot) as seen on o_state
// ----------------------------------------
`define LAFSM_ST_W           12
`define LAFSM_ST_DEACT       12'h001
`define LAFSM_ST_WAKE_RSP    12'h002
`define LAFSM_ST_WAKE_REQ    12'h004
`define LAFSM_ST_TRAIN       12'h008
`define LAFSM_ST_SYNCED      12'h010
`define LAFSM_ST_PREACT      12'h020
`define LAFSM_ST_ACTIVE      12'h040
`define LAFSM_ST_PEND_DEACT  12'h080
`define LAFSM_ST_LOOP_WAKE   12'h100
`define LAFSM_ST_LOOP_SYNC   12'h200
`define LAFSM_ST_LOOP_PREACT 12'h400
`define LAFSM_ST_LOOP_ACTIVE 12'h800

// ----------------------------------------
// timer durations in microseconds and clock rate
// ----------------------------------------
`define LAFSM_CLK_MHZ        40
`define LAFSM_WAKE_ACK_US    1000
`define LAFSM_PRE_ACTIVE_US  1000
`define LAFSM_LOOP_WAKE_US   1000
`define LAFSM_CYC(us)        ((us) * `LAFSM_CLK_MHZ)
// the same durations in clock cycles, sized to the timer width
`define LAFSM_WAKE_ACK_CYC   24'h009C40
`define LAFSM_PRE_ACTIVE_CYC 24'h009C40
`define LAFSM_LOOP_WAKE_CYC  24'h009C40
`define LAFSM_TMR_W          24

// ----------------------------------------
// activation time limits in microseconds
// ----------------------------------------
`define LAFSM_ACT_FAST_US    210000
`define LAFSM_ACT_FAST_REG_US 420000
`define LAFSM_ACT_COLD_US    1500000
`define LAFSM_ACT_COLD_REG_US 3000000

`endif

// ==== logic/lafsm_line_activation.v ====
// activation and deactivation state machine of the exchange-side line termination
`timescale 1ns/1ps
// Notes on behaviour
// - deactivated sends quiet; activate request wakes
// - remote wakeup: start timer, indicate, answer
// - wake timer expiry trains; new wakeup defers
// - wake request sends wakeup, remote wakeup trains
// - training synced with remote sync: indicate
// - remote user sync starts pre-active timer
// - pre-active sends pre-active until expiry
// - active sends active, indicates fully active
// - deactivate request goes pending, sends quiet
// - remote quiet in pending: indicate, deactivate
// - framing loss or quiet in synced, pre-active or active: fault indication
// - loopback one request: from deactivated or pending loop wake, timer; from wake request, training or synced loop syncing
// - loop wake expiry: train, loop syncing
// - loop synced: start pre-active timer
// - loop pre-active expiry: indicate, loop active
// - loop active sends active, loopback operated
// - other loopback requests leave states alone
// - fast activation within 210 or 420 ms
// - cold activation within 1,5 or 3 s
`include "lafsm_map.vh"

module lafsm_line_activation #(
  parameter [`LAFSM_TMR_W-1:0] WAKE_ACK_CYC   = `LAFSM_WAKE_ACK_CYC,
  parameter [`LAFSM_TMR_W-1:0] PRE_ACTIVE_CYC = `LAFSM_PRE_ACTIVE_CYC,
  parameter [`LAFSM_TMR_W-1:0] LOOP_WAKE_CYC  = `LAFSM_LOOP_WAKE_CYC
) (
  input  wire                   i_clk_sys,
  input  wire                   i_reset,
  input  wire                   i_activate_request,
  input  wire                   i_deactivate_request,
  input  wire                   i_loopback_one_request,
  input  wire                   i_rx_quiet,
  input  wire                   i_rx_remote_wakeup,
  input  wire                   i_rx_remote_sync,
  input  wire                   i_rx_remote_user_sync,
  input  wire                   i_rx_synced,
  input  wire                   i_rx_framing_lost,
  input  wire                   i_loop_synced,
  output reg  [2:0]             o_tx_signal,
  output reg                    o_loopback_one,
  output reg                    o_remote_wakeup_indication,
  output reg                    o_line_synced_indication,
  output reg                    o_fully_active_indication,
  output reg                    o_deactivated_indication,
  output reg                    o_line_fault_indication,
  output reg  [`LAFSM_ST_W-1:0] o_state
);

  // ----------------------------------------
  // state encoding
  // ----------------------------------------
  localparam [`LAFSM_ST_W-1:0] S_DEACT       = `LAFSM_ST_DEACT;
  localparam [`LAFSM_ST_W-1:0] S_WAKE_RSP    = `LAFSM_ST_WAKE_RSP;
  localparam [`LAFSM_ST_W-1:0] S_WAKE_REQ    = `LAFSM_ST_WAKE_REQ;
  localparam [`LAFSM_ST_W-1:0] S_TRAIN       = `LAFSM_ST_TRAIN;
  localparam [`LAFSM_ST_W-1:0] S_SYNCED      = `LAFSM_ST_SYNCED;
  localparam [`LAFSM_ST_W-1:0] S_PREACT      = `LAFSM_ST_PREACT;
  localparam [`LAFSM_ST_W-1:0] S_ACTIVE      = `LAFSM_ST_ACTIVE;
  localparam [`LAFSM_ST_W-1:0] S_PEND_DEACT  = `LAFSM_ST_PEND_DEACT;
  localparam [`LAFSM_ST_W-1:0] S_LOOP_WAKE   = `LAFSM_ST_LOOP_WAKE;
  localparam [`LAFSM_ST_W-1:0] S_LOOP_SYNC   = `LAFSM_ST_LOOP_SYNC;
  localparam [`LAFSM_ST_W-1:0] S_LOOP_PREACT = `LAFSM_ST_LOOP_PREACT;
  localparam [`LAFSM_ST_W-1:0] S_LOOP_ACTIVE = `LAFSM_ST_LOOP_ACTIVE;
  localparam [`LAFSM_TMR_W-1:0] TMR_ONE      = 24'h000001;

  // ----------------------------------------
  // transmit signal per state
  // ----------------------------------------
  function [2:0] tx_of;
    input [`LAFSM_ST_W-1:0] st;
    begin
      case (st)
        S_WAKE_RSP, S_WAKE_REQ, S_LOOP_WAKE: tx_of = `LAFSM_TX_WAKE;
        S_TRAIN, S_SYNCED, S_LOOP_SYNC:      tx_of = `LAFSM_TX_TRAIN;
        S_PREACT, S_LOOP_PREACT:             tx_of = `LAFSM_TX_PREACT;
        S_ACTIVE, S_LOOP_ACTIVE:             tx_of = `LAFSM_TX_ACTIVE;
        default:                             tx_of = `LAFSM_TX_QUIET;
      endcase
    end
  endfunction

  // ----------------------------------------
  // state and timer registers
  // ----------------------------------------
  reg [`LAFSM_ST_W-1:0] state;
  reg [`LAFSM_ST_W-1:0] next_state;
  reg [`LAFSM_TMR_W-1:0] timer;
  reg [`LAFSM_TMR_W-1:0] next_timer;
  reg                    next_wake_ind;
  reg                    next_sync_ind;
  reg                    next_full_ind;
  reg                    next_deact_ind;
  reg                    next_fault_ind;

  // one shared down-counter: only one of the three timers is ever running
  wire timer_expired = (timer == TMR_ONE);

  always @* begin
    next_state     = state;
    next_timer     = (timer != {`LAFSM_TMR_W{1'b0}}) ? timer - TMR_ONE : timer;
    next_wake_ind  = 1'b0;
    next_sync_ind  = 1'b0;
    next_full_ind  = 1'b0;
    next_deact_ind = 1'b0;
    next_fault_ind = 1'b0;
    // loopback 2 and 1A travel over the control channels, no input here
    if (i_deactivate_request && state != S_DEACT && state != S_PEND_DEACT) begin
      next_state = S_PEND_DEACT;
      next_timer = {`LAFSM_TMR_W{1'b0}};
    end else begin
      case (state)
        S_DEACT: begin
          if (i_loopback_one_request) begin
            next_state = S_LOOP_WAKE;
            next_timer = LOOP_WAKE_CYC;
          end else if (i_rx_remote_wakeup) begin
            next_state    = S_WAKE_RSP;
            next_timer    = WAKE_ACK_CYC;
            next_wake_ind = 1'b1;
          end else if (i_activate_request) begin
            next_state = S_WAKE_REQ;
          end
        end
        S_WAKE_RSP: begin
          if (i_rx_remote_wakeup) begin
            next_timer = WAKE_ACK_CYC;
          end else if (timer_expired) begin
            next_state = S_TRAIN;
          end
        end
        S_WAKE_REQ: begin
          if (i_loopback_one_request) begin
            next_state = S_LOOP_SYNC;
          end else if (i_rx_remote_wakeup) begin
            next_state = S_TRAIN;
          end
        end
        S_TRAIN: begin
          if (i_loopback_one_request) begin
            next_state = S_LOOP_SYNC;
          end else if (i_rx_remote_user_sync) begin
            next_state = S_PREACT;
            next_timer = PRE_ACTIVE_CYC;
          end else if (i_rx_synced && i_rx_remote_sync) begin
            next_state    = S_SYNCED;
            next_sync_ind = 1'b1;
          end
        end
        S_SYNCED: begin
          if (i_loopback_one_request) begin
            next_state = S_LOOP_SYNC;
          end else if (i_rx_remote_user_sync) begin
            next_state = S_PREACT;
            next_timer = PRE_ACTIVE_CYC;
          end
          next_fault_ind = i_rx_quiet | i_rx_framing_lost;
        end
        S_PREACT: begin
          // expiry here means the remote never reached active: fault, retrain
          if (timer_expired) begin
            next_state     = S_TRAIN;
            next_fault_ind = 1'b1;
          end else begin
            next_fault_ind = i_rx_quiet | i_rx_framing_lost;
          end
        end
        S_ACTIVE: begin
          next_full_ind  = 1'b1;
          next_fault_ind = i_rx_quiet | i_rx_framing_lost;
        end
        S_PEND_DEACT: begin
          if (i_loopback_one_request) begin
            next_state = S_LOOP_WAKE;
            next_timer = LOOP_WAKE_CYC;
          end else if (i_rx_quiet) begin
            next_state     = S_DEACT;
            next_deact_ind = 1'b1;
          end
        end
        S_LOOP_WAKE: begin
          if (timer_expired) begin
            next_state = S_LOOP_SYNC;
          end
        end
        S_LOOP_SYNC: begin
          if (i_loop_synced) begin
            next_state = S_LOOP_PREACT;
            next_timer = PRE_ACTIVE_CYC;
          end
        end
        S_LOOP_PREACT: begin
          if (timer_expired) begin
            next_state    = S_LOOP_ACTIVE;
            next_full_ind = 1'b1;
          end
        end
        S_LOOP_ACTIVE: begin
          next_full_ind = 1'b1;
        end
        default: begin
          next_state = S_DEACT;
          next_timer = {`LAFSM_TMR_W{1'b0}};
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers; every output is a flip-flop
  // ----------------------------------------
  // activation times depend on the far end and the line; timer defaults
  // are kept far below them so the local share stays small
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state                      <= S_DEACT;
      timer                      <= {`LAFSM_TMR_W{1'b0}};
      o_state                    <= S_DEACT;
      o_tx_signal                <= `LAFSM_TX_QUIET;
      o_loopback_one             <= 1'b0;
      o_remote_wakeup_indication <= 1'b0;
      o_line_synced_indication   <= 1'b0;
      o_fully_active_indication  <= 1'b0;
      o_deactivated_indication   <= 1'b0;
      o_line_fault_indication    <= 1'b0;
    end else begin
      state                      <= next_state;
      timer                      <= next_timer;
      o_state                    <= next_state;
      o_tx_signal                <= tx_of(next_state);
      o_loopback_one             <= (next_state == S_LOOP_SYNC) ||
                                    (next_state == S_LOOP_PREACT) ||
                                    (next_state == S_LOOP_ACTIVE);
      o_remote_wakeup_indication <= next_wake_ind;
      o_line_synced_indication   <= next_sync_ind;
      o_fully_active_indication  <= next_full_ind;
      o_deactivated_indication   <= next_deact_ind;
      o_line_fault_indication    <= next_fault_ind;
    end
  end

endmodule // lafsm_line_activation

// ==== verification/lafsm_line_activation_asserts.sv ====
// concurrent checks on the line activation state machine ports
`timescale 1ns/1ps
`include "lafsm_map.vh"
module lafsm_line_activation_asserts (
  input wire                   i_clk_sys,
  input wire                   i_reset,
  input wire                   i_activate_request,
  input wire                   i_deactivate_request,
  input wire                   i_loopback_one_request,
  input wire                   i_rx_quiet,
  input wire                   i_rx_remote_wakeup,
  input wire                   i_rx_remote_sync,
  input wire                   i_rx_remote_user_sync,
  input wire                   i_rx_synced,
  input wire                   i_rx_framing_lost,
  input wire [2:0]             o_tx_signal,
  input wire                   o_loopback_one,
  input wire                   o_remote_wakeup_indication,
  input wire                   o_line_synced_indication,
  input wire                   o_fully_active_indication,
  input wire                   o_deactivated_indication,
  input wire                   o_line_fault_indication,
  input wire [`LAFSM_ST_W-1:0] o_state
);
  // ----------------------------------------
  // state relations
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // deactivate and loopback outrank every other event, so they are excluded
  wire calm = !i_deactivate_request && !i_loopback_one_request;
  a_quiet_idle: assert property (o_state == `LAFSM_ST_DEACT |-> o_tx_signal == `LAFSM_TX_QUIET)
    else $error("deactivated state not quiet");
  a_wake_answer: assert property (o_state == `LAFSM_ST_DEACT && i_rx_remote_wakeup && calm |=>
    o_state == `LAFSM_ST_WAKE_RSP && o_remote_wakeup_indication && o_tx_signal == `LAFSM_TX_WAKE)
    else $error("remote wakeup not answered");
  a_wake_request: assert property (o_state == `LAFSM_ST_DEACT && i_activate_request && calm &&
    !i_rx_remote_wakeup |=> o_state == `LAFSM_ST_WAKE_REQ && o_tx_signal == `LAFSM_TX_WAKE)
    else $error("activate request not taken");
  a_req_train: assert property (o_state == `LAFSM_ST_WAKE_REQ && i_rx_remote_wakeup && calm |=>
    o_state == `LAFSM_ST_TRAIN)
    else $error("wake request did not train");
  a_train_synced: assert property (o_state == `LAFSM_ST_TRAIN && i_rx_synced && i_rx_remote_sync &&
    !i_rx_remote_user_sync && calm |=> o_state == `LAFSM_ST_SYNCED && o_line_synced_indication)
    else $error("training did not sync");
  a_user_sync: assert property ((o_state == `LAFSM_ST_TRAIN || o_state == `LAFSM_ST_SYNCED) &&
    i_rx_remote_user_sync && calm |=> o_state == `LAFSM_ST_PREACT && o_tx_signal == 3'h3)
    else $error("user sync not taken");
  a_pend_enter: assert property (i_deactivate_request && o_state != `LAFSM_ST_DEACT &&
    o_state != `LAFSM_ST_PEND_DEACT |=> o_state == `LAFSM_ST_PEND_DEACT && o_tx_signal == 3'h0)
    else $error("deactivate not taken");
  a_pend_done: assert property (o_state == `LAFSM_ST_PEND_DEACT && i_rx_quiet && calm |=>
    o_state == `LAFSM_ST_DEACT && o_deactivated_indication)
    else $error("pending deactivation not closed");
  a_line_fault: assert property ((o_state & 12'h070) != 12'h000 && !i_deactivate_request &&
    (i_rx_framing_lost || i_rx_quiet) |=> o_line_fault_indication)
    else $error("line fault not indicated");
  a_loop_held: assert property ((o_state & 12'hE00) != 12'h000 |-> o_loopback_one)
    else $error("loopback not operated");
  a_loop_full: assert property (o_state == `LAFSM_ST_LOOP_ACTIVE |->
    o_tx_signal == `LAFSM_TX_ACTIVE && o_fully_active_indication)
    else $error("loop active outputs wrong");
endmodule // lafsm_line_activation_asserts
bind lafsm_line_activation lafsm_line_activation_asserts chk_i (.*);

// ==== verification/lafsm_remote_model.sv ====
// behavioural remote termination unit at the far end of the line
`timescale 1ns/1ps
module lafsm_remote_model (
  input  wire       i_clk_sys,
  input  wire       i_reset,
  input  wire [2:0] i_tx_signal,
  input  wire       i_loopback_one,
  input  wire       i_call,
  input  wire       i_slow,
  input  wire       i_user_go,
  output reg        o_wakeup,
  output wire       o_quiet,
  output wire       o_sync,
  output wire       o_user_sync,
  output wire       o_loop_synced
);
  reg [2:0] last;
  reg [3:0] age;
  reg       done;
  reg       calling;
  // every answer waits a lag after a change of the line code: a slow far end waits six cycles instead of one
  wire ready = (last == i_tx_signal) && (age >= (i_slow ? 4'h6 : 4'h1));
  assign o_quiet = ready && i_tx_signal == 3'h0;
  assign o_sync = ready && i_tx_signal == 3'h2 && !i_loopback_one;
  assign o_loop_synced = ready && i_tx_signal == 3'h2 && i_loopback_one;
  assign o_user_sync = o_sync && i_user_go;
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      {last, age, done, calling, o_wakeup} <= 10'h000;
    end else begin
      last <= i_tx_signal;
      age <= (last != i_tx_signal) ? 4'h0 : (ready ? age : age + 4'h1);
      done <= (last != i_tx_signal) ? 1'b0 : (done || ready);
      calling <= i_call || (calling && i_tx_signal != 3'h2);
      // a far end that called does not acknowledge the answer, so the wake timer runs out
      o_wakeup <= i_call || (i_tx_signal == 3'h1 && ready && !done && !calling);
    end
  end
endmodule // lafsm_remote_model

// ==== verification/tb.sv ====
// self-checking bench for the line activation state machine
`timescale 1ns/1ps
`include "lafsm_map.vh"
module tb;
  logic i_clk_sys, i_reset, i_activate_request, i_deactivate_request, i_loopback_one_request;
  logic i_rx_framing_lost, call, slow, user_go;
  wire  i_rx_quiet, i_rx_remote_wakeup, i_rx_remote_sync, i_rx_remote_user_sync;
  wire  i_rx_synced, i_loop_synced, o_loopback_one, o_remote_wakeup_indication;
  wire  o_line_synced_indication, o_fully_active_indication, o_deactivated_indication;
  wire  o_line_fault_indication;
  wire  [2:0] o_tx_signal;
  wire  [11:0] o_state;
  integer errors, samples_checked, n;
  assign i_rx_remote_sync = i_rx_synced;
  lafsm_line_activation #(.WAKE_ACK_CYC(24'h8), .PRE_ACTIVE_CYC(24'h8), .LOOP_WAKE_CYC(24'h8))
    lafsm_line_activation_i (.*);
  lafsm_remote_model lafsm_remote_model_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_tx_signal(o_tx_signal), .i_loopback_one(o_loopback_one), .i_call(call), .i_slow(slow),
    .i_user_go(user_go), .o_wakeup(i_rx_remote_wakeup), .o_quiet(i_rx_quiet),
    .o_sync(i_rx_synced), .o_user_sync(i_rx_remote_user_sync), .o_loop_synced(i_loop_synced));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic ok, input string msg);
    samples_checked = samples_checked + 1;
    if (ok !== 1'b1) begin
      errors = errors + 1;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task wait_st(input [11:0] exp);
    for (n = 0; n < 200 && o_state !== exp; n = n + 1) @(negedge i_clk_sys);
    chk(o_state === exp, "state not reached");
  endtask
  task pulse(input [2:0] which);
    {i_loopback_one_request, i_deactivate_request, i_activate_request} = which;
    @(negedge i_clk_sys) {i_loopback_one_request, i_deactivate_request, i_activate_request} = 3'h0;
  endtask
  task print_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_incoming;
    @(negedge i_clk_sys) call = 1'b1;
    @(negedge i_clk_sys) call = 1'b0;
    wait_st(`LAFSM_ST_WAKE_RSP);
    chk(o_remote_wakeup_indication === 1'b1 && o_tx_signal === 3'h1, "no wake answer");
    repeat (7) @(negedge i_clk_sys);
    chk(o_state === `LAFSM_ST_WAKE_RSP, "wake timer early");
    @(negedge i_clk_sys) chk(o_state === 12'h008 && o_tx_signal === 3'h2, "wake timer late");
    wait_st(`LAFSM_ST_SYNCED);
    chk(o_line_synced_indication === 1'b1, "no synced pulse");
    user_go = 1'b1;
    wait_st(`LAFSM_ST_PREACT);
    user_go = 1'b0;
    chk(o_tx_signal === `LAFSM_TX_PREACT, "not pre-active");
    pulse(3'h2);
    wait_st(`LAFSM_ST_PEND_DEACT);
    chk(o_tx_signal === `LAFSM_TX_QUIET, "pending not quiet");
    wait_st(`LAFSM_ST_DEACT);
    chk(o_deactivated_indication === 1'b1, "no deactivated pulse");
  endtask
  task t_request;
    slow = 1'b1;
    pulse(3'h2);
    chk(o_state === 12'h001 && o_tx_signal === 3'h0, "deactivate in idle moved");
    pulse(3'h1);
    wait_st(`LAFSM_ST_WAKE_REQ);
    chk(o_tx_signal === `LAFSM_TX_WAKE, "no wake request");
    wait_st(`LAFSM_ST_TRAIN);
    wait_st(`LAFSM_ST_SYNCED);
    i_rx_framing_lost = 1'b1;
    @(negedge i_clk_sys) chk(o_line_fault_indication === 1'b1, "no fault");
    i_rx_framing_lost = 1'b0;
    pulse(3'h2);
    wait_st(`LAFSM_ST_DEACT);
    slow = 1'b0;
  endtask
  task t_loop;
    pulse(3'h4);
    wait_st(`LAFSM_ST_LOOP_WAKE);
    chk(o_tx_signal === `LAFSM_TX_WAKE, "loop wake code");
    wait_st(`LAFSM_ST_LOOP_SYNC);
    chk(o_tx_signal === 3'h2 && o_loopback_one === 1'b1, "loop sync outputs");
    wait_st(`LAFSM_ST_LOOP_PREACT);
    chk(o_tx_signal === `LAFSM_TX_PREACT, "loop pre-active code");
    wait_st(`LAFSM_ST_LOOP_ACTIVE);
    chk(o_tx_signal === 3'h4 && o_fully_active_indication === 1'b1, "loop active");
    pulse(3'h2);
    wait_st(`LAFSM_ST_PEND_DEACT);
    wait_st(`LAFSM_ST_DEACT);
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // far end may hang the handshake; cut the run well beyond the expected hundred or so cycles
  initial begin
    #500000;
    errors = errors + 1;
    print_verdict;
  end
  initial begin
    {i_reset, i_activate_request, i_deactivate_request, i_loopback_one_request} = 4'h8;
    {i_rx_framing_lost, call, slow, user_go} = 4'h0;
    errors = 0;
    samples_checked = 0;
    repeat (8) @(negedge i_clk_sys);
    i_reset = 1'b0;
    @(negedge i_clk_sys);
    chk(o_state === `LAFSM_ST_DEACT && o_tx_signal === `LAFSM_TX_QUIET &&
      {o_loopback_one, o_remote_wakeup_indication, o_line_synced_indication,
      o_fully_active_indication, o_deactivated_indication, o_line_fault_indication} === 6'h00,
      "reset values");
    t_incoming;
    t_request;
    t_loop;
    print_verdict;
  end
endmodule // tb
